// file: dv/net_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module net_side_model (
	// Clock
	input  wire logic                    i_clk,
	// Serial side
	input  wire logic                    i_rx_ready,
	output logic                         o_rx_valid,
	output logic [7:0]                   o_rx_data,
	// Frame side
	input  wire packer_pkg::frame_byte_s i_tx,
	input  wire logic                    i_tx_valid,
	output logic                         o_tx_ready
);
	logic [8:0] got_q [$];
	logic       slow;
	logic [1:0] tick;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data  = 8'h00;
		o_tx_ready = 1'b0;
		slow       = 1'b0;
		tick       = 2'h0;
	end
	task automatic send(input logic [7:0] b);
		o_rx_valid <= 1'b1;
		o_rx_data  <= b;
		@(posedge i_clk);
		while (i_rx_ready !== 1'b1) @(posedge i_clk);
	endtask
	// Released line shows inverse data
	task automatic idle();
		o_rx_valid <= 1'b0;
		o_rx_data  <= ~o_rx_data;
		@(posedge i_clk);
	endtask
	// Sink stalls three cycles of four when slow
	always @(posedge i_clk) begin
		tick       <= tick + 2'h1;
		o_tx_ready <= !slow || (tick == 2'h3);
		if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) got_q.push_back({i_tx.data, i_tx.last});
	end
endmodule // net_side_model
`default_nettype wire

// file: dv/packer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module packer_chk (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	// Bus handshake
	input  wire logic                    i_avs_read,
	input  wire logic                    i_avs_write,
	input  wire logic [31:0]             o_avs_readdata,
	input  wire logic                    o_avs_waitrequest,
	// Streams
	input  wire logic                    o_rx_ready,
	input  wire packer_pkg::frame_byte_s o_tx,
	input  wire logic                    o_tx_valid,
	input  wire logic                    i_tx_ready,
	// Configuration and link
	input  wire packer_pkg::dest_entry_s o_dest [packer_pkg::NUM_DEST],
	input  wire logic [15:0]             o_listen_port,
	input  wire logic [15:0]             o_stream_listen_port,
	input  wire logic                    i_link_open,
	input  wire logic                    i_link_activity,
	input  wire logic                    o_link_close
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// Bus answers
	wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	req_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("request not answered");
	rdata_hold_a: assert property (!i_avs_read && !i_avs_write |=> $stable(o_avs_readdata))
		else $error("readdata moved while idle");
	// Frame stream
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx))
		else $error("frame byte dropped under stall");
	rx_stall_a: assert property (o_tx_valid |-> !o_rx_ready)
		else $error("serial input open while sending");
	tx_start_a: assert property ($fell(o_rx_ready) |-> ##[0:2] o_tx_valid)
		else $error("frame did not start");
	frame_resume_a: assert property (o_tx_valid && i_tx_ready && o_tx.last
		|=> !o_tx_valid ##[0:1] o_rx_ready) else $error("no resume after frame");
	// Link supervision and configuration hold
	close_pulse_a: assert property (o_link_close |=> !o_link_close)
		else $error("close longer than a pulse");
	close_cause_a: assert property (o_link_close
		|-> $past(i_link_open) && !$past(i_link_activity)) else $error("close without idle");
	cfg_hold_a: assert property (!i_avs_write |=> $stable(o_listen_port)
		&& $stable(o_stream_listen_port) && $stable(o_dest[3])) else $error("config moved");

	// Main scenarios
	cover property (o_tx_valid && i_tx_ready && o_tx.last);
	cover property (o_tx_valid && !i_tx_ready);
	cover property (o_link_close);
endmodule // packer_chk
bind serial_to_datagram_packer packer_chk chk (.*);
`default_nettype wire

// file: dv/serial_to_datagram_packer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module serial_to_datagram_packer_tb_top;
	logic                    i_clk = 1'b0, i_reset = 1'b1;
	logic [7:0]              i_avs_address = 8'h00, i_rx_data;
	logic                    i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [31:0]             i_avs_writedata = 32'h0, o_avs_readdata, q;
	logic [3:0]              i_avs_byteenable = 4'hF;
	logic                    o_avs_waitrequest, i_rx_valid, o_rx_ready, o_tx_valid, i_tx_ready;
	logic                    i_link_open = 1'b0, i_link_activity = 1'b0, o_link_close;
	logic [15:0]             o_listen_port, o_stream_listen_port;
	packer_pkg::frame_byte_s o_tx;
	packer_pkg::dest_entry_s o_dest [packer_pkg::NUM_DEST];
	int                      errors = 0, comparisons = 0, closes = 0, n;
	logic [7:0]              exp_q [$];

	serial_to_datagram_packer #(.MS_CYCLES(10), .MS_PER_MIN(4), .BUF_DEPTH(16)) dut (.*);
	net_side_model m (.i_clk(i_clk), .i_rx_ready(o_rx_ready), .o_rx_valid(i_rx_valid),
		.o_rx_data(i_rx_data), .i_tx(o_tx), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready));

	// Clock, close counter and watchdog
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_link_close === 1'b1) closes++;
	initial begin
		repeat (20000) @(posedge i_clk);
		errors++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus access, held until waitrequest is low; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		i_avs_address   <= a;
		i_avs_writedata <= d;
		i_avs_write     <= wr;
		i_avs_read      <= !wr;
		@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0) begin
			@(posedge i_clk);
			k++;
		end
		q = o_avs_readdata;
		check("bus wait", 32'(k), 32'h1);
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), q, exp);
	endtask
	task automatic push(input logic [7:0] b);
		exp_q.push_back(b);
		m.send(b);
	endtask
	// Waits for the frame, compares bytes, last flag and cause
	task automatic frame(input string what, input logic [1:0] cause);
		int k;
		k = 0;
		m.idle();
		while (m.got_q.size() < exp_q.size() && k < 400) begin
			@(posedge i_clk);
			k++;
		end
		repeat (4) @(posedge i_clk);
		check({what, " len"}, m.got_q.size(), exp_q.size());
		foreach (exp_q[i])
			check(what, (i < m.got_q.size()) ? m.got_q[i] : 9'h0, {exp_q[i], i == exp_q.size() - 1});
		bus(1'b0, 8'h14, 32'h0);
		check({what, " cause"}, q[5:4], cause);
		m.got_q.delete();
		exp_q.delete();
		$display("test %s done", what);
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		rd(8'h08, 32'h0FA1);
		rd(8'h0C, 32'h0FA1);
		rd(8'h10, 32'h7);
		rd(8'h04, 32'h0);
		rd(8'h28, 32'h0FA1);
		rd(8'h58, 32'h0FA1);
		rd(8'h50, 32'h0);
		rd(8'h18, 32'h0);
		check("dest1 port", o_dest[1].port, 32'h0FA1);
		$display("test reset done");
		bus(1'b1, 8'h08, 32'hFFFF);
		check("listen port", o_listen_port, 32'hFFFF);
		bus(1'b1, 8'h0C, 32'h1);
		check("stream port", o_stream_listen_port, 32'h1);
		// Single lane write keeps the other lanes
		i_avs_byteenable <= 4'h2;
		bus(1'b1, 8'h0C, 32'h0000AB00);
		i_avs_byteenable <= 4'hF;
		check("stream lane", o_stream_listen_port, 32'hAB01);
		bus(1'b1, 8'h54, 32'hC0A80114);
		bus(1'b1, 8'h58, 32'h0FA2);
		check("dest3 end", o_dest[3].addr_end, 32'hC0A80114);
		check("dest3 port", o_dest[3].port, 32'h0FA2);
		bus(1'b1, 8'h10, 32'h64);
		rd(8'h10, 32'h63);
		$display("test config done");
		bus(1'b1, 8'h00, 32'h007E0002);
		push(8'h7E);
		push(8'h11);
		m.idle();
		repeat (60) @(posedge i_clk);
		check("no flush", m.got_q.size(), 32'h0);
		bus(1'b1, 8'h00, 32'h0000FF01);
		push(8'hFF);
		frame("marker1 only", 2'h1);
		m.slow = 1'b1;
		bus(1'b1, 8'h00, 32'h007E0003);
		push(8'h00);
		push(8'h55);
		push(8'h00);
		push(8'h7E);
		frame("two markers", 2'h1);
		push(8'h7E);
		push(8'h00);
		push(8'h7E);
		frame("marker2 first", 2'h1);
		m.slow = 1'b0;
		bus(1'b1, 8'h00, 32'h0);
		for (int i = 0; i < 16; i++) push(i[7:0]);
		frame("full", 2'h2);
		bus(1'b1, 8'h04, 32'h2);
		push(8'hA1);
		push(8'hA2);
		push(8'hA3);
		frame("timeout", 2'h3);
		bus(1'b1, 8'h10, 32'h1);
		i_link_open <= 1'b1;
		n = 0;
		while (closes == 0 && n < 100) begin
			@(posedge i_clk);
			n++;
		end
		i_link_open <= 1'b0;
		check("idle close", closes, 32'h1);
		check("close early", 32'(n >= 38), 32'h1);
		@(posedge i_clk);
		i_link_open <= 1'b1;
		repeat (10) begin
			repeat (20) @(posedge i_clk);
			i_link_activity <= 1'b1;
			@(posedge i_clk);
			i_link_activity <= 1'b0;
		end
		bus(1'b1, 8'h10, 32'h0);
		repeat (150) @(posedge i_clk);
		check("no idle close", closes, 32'h1);
		$display("test link done");
		wrap_up();
	end
endmodule // serial_to_datagram_packer_tb_top
`default_nettype wire

// file: src/packer_pkg.sv
// Functional notes
// [R1] Both marker bytes accept any value 00..FF; marker1 then marker2 received flushes the buffer.
// [R2] With marker2 disabled, marker1 alone flushes and clears the buffered data.
// [R3] When the 1 KB buffer fills without another flush, the data is flushed automatically.
// [R4] Marker flushing needs marker1 enabled; marker2 alone is a setup software must avoid.
// [R5] The flush timeout is 0..65535 ms, default 0, and zero disables timeout flushing.
// [R6] A nonzero timeout keeps all bytes received within that interval in one frame.
// [R7] Serial bytes are stored in the buffer and leave only on a flush condition.
// [R8] Software should set the timeout above one character time, e.g. 10 ms at 1200 bps.
// [R9] The serial device should send a packet's bytes within the timeout and within 1 KB.
// [R10] Four destination entries of begin address, end address and port, port default 4001.
// [R11] Datagram listen port 1..65535, default 4001, presented to the network side.
// [R12] Idle link timeout 0..99 minutes, default 7; zero never closes, else close when idle.
// [R13] Stream listen port 1..65535, default 4001, presented to the network side.
// [R14] After any flush the buffer, the timeout count and any partial marker match are cleared.
package packer_pkg;

	// Buffer geometry and destination count
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned BUF_DEPTH = 1024;
	localparam int unsigned NUM_DEST  = 4;

	// Timing
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned MS_PER_S   = 1000;
	localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S;
	localparam int unsigned S_PER_MIN  = 60;
	localparam int unsigned MS_PER_MIN = S_PER_MIN * MS_PER_S;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_FLUSH_TMO = 8'h04;
	localparam logic [7:0] REG_LISTEN    = 8'h08;
	localparam logic [7:0] REG_STREAM    = 8'h0C;
	localparam logic [7:0] REG_IDLE      = 8'h10;
	localparam logic [7:0] REG_STATUS    = 8'h14;
	localparam logic [7:0] REG_DEST_BASE = 8'h20;
	localparam logic [7:0] REG_DEST_END  = 8'h5C;

	// Destination entry word select (address bits 3:2)
	localparam logic [1:0] DEST_BEGIN = 2'h0;
	localparam logic [1:0] DEST_LAST  = 2'h1;
	localparam logic [1:0] DEST_PORT  = 2'h2;

	// Field positions
	localparam int unsigned CTRL_M1_EN   = 0;
	localparam int unsigned CTRL_M2_EN   = 1;
	localparam int unsigned CTRL_M1_LSB  = 8;
	localparam int unsigned CTRL_M2_LSB  = 16;
	localparam int unsigned STAT_SENDING = 0;
	localparam int unsigned STAT_LINK    = 1;
	localparam int unsigned STAT_CAUSE   = 4;
	localparam int unsigned STAT_FILL    = 16;

	// Reset values and idle cap
	localparam logic [15:0] FLUSH_TMO_RST = 16'h0000;
	localparam logic [15:0] PORT_RST      = 16'h0FA1;
	localparam logic [6:0]  IDLE_RST      = 7'h07;
	localparam logic [6:0]  IDLE_MAX      = 7'h63;

	// Flush causes
	localparam logic [1:0] CAUSE_MARKER  = 2'h1;
	localparam logic [1:0] CAUSE_FULL    = 2'h2;
	localparam logic [1:0] CAUSE_TIMEOUT = 2'h3;

	typedef struct packed {
		logic [31:0] addr_begin;
		logic [31:0] addr_end;
		logic [15:0] port;
	} dest_entry_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              last;
	} frame_byte_s;

endpackage

// file: src/serial_to_datagram_packer.sv
`timescale 1ns/100ps
`default_nettype none
module serial_to_datagram_packer #(
	parameter int unsigned MS_CYCLES  = packer_pkg::MS_CYCLES,
	parameter int unsigned MS_PER_MIN = packer_pkg::MS_PER_MIN,
	parameter int unsigned BUF_DEPTH  = packer_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	// Avalon-MM register slave
	input  wire logic [7:0]             i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [31:0]            i_avs_writedata,
	input  wire logic [3:0]             i_avs_byteenable,
	output logic      [31:0]            o_avs_readdata,
	output logic                        o_avs_waitrequest,
	// Serial byte stream in
	input  wire logic                   i_rx_valid,
	input  wire logic [7:0]             i_rx_data,
	output logic                        o_rx_ready,
	// Frame stream out
	output packer_pkg::frame_byte_s     o_tx,
	output logic                        o_tx_valid,
	input  wire logic                   i_tx_ready,
	// Network configuration
	output packer_pkg::dest_entry_s     o_dest [packer_pkg::NUM_DEST],
	output logic      [15:0]            o_listen_port,
	output logic      [15:0]            o_stream_listen_port,
	// Stream link supervision
	input  wire logic                   i_link_open,
	input  wire logic                   i_link_activity,
	output logic                        o_link_close
);
	localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);
	localparam int unsigned AW    = $clog2(BUF_DEPTH);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(BUF_DEPTH);

	typedef enum logic [1:0] {
		FILL_ST = 2'b01,
		SEND_ST = 2'b10
	} frame_state_e;

	// Configuration and bus state
	logic                    wait_r, wait_nxt;
	logic [31:0]             rdata_r, rdata_nxt;
	logic [31:0]             ctrl_r, ctrl_nxt;
	logic [15:0]             flush_tmo_r, flush_tmo_nxt;
	logic [15:0]             listen_r, listen_nxt;
	logic [15:0]             stream_r, stream_nxt;
	logic [6:0]              idle_r, idle_nxt;
	packer_pkg::dest_entry_s dest_r [packer_pkg::NUM_DEST];
	packer_pkg::dest_entry_s dest_nxt [packer_pkg::NUM_DEST];

	// Frame state
	frame_state_e            state_r, state_nxt;
	logic [CNT_W-1:0]        count_r, count_nxt;
	logic [CNT_W-1:0]        len_r, len_nxt;
	logic [CNT_W-1:0]        rd_r, rd_nxt;
	logic                    match_r, match_nxt;
	logic [15:0]             ms_cnt_r, ms_cnt_nxt;
	logic                    rx_ready_r, rx_ready_nxt;
	logic                    tx_valid_r, tx_valid_nxt;
	packer_pkg::frame_byte_s tx_r, tx_nxt;
	logic [1:0]              cause_r, cause_nxt;
	logic [7:0]              mem [BUF_DEPTH];

	// Link state
	logic [6:0]              idle_min_r, idle_min_nxt;
	logic                    close_r, close_nxt;

	// Decoded helpers
	logic             req, take;
	logic [31:0]      wmask, rd_word;
	logic             accept, frame_start, link_clear;
	logic             m1_en, m2_en, hit1, hit2;
	logic             marker_flush, full_flush, tmo_flush;
	logic [CNT_W-1:0] count_inc;
	logic             frame_ms_tick, link_ms_tick, link_min_tick;
	logic [1:0]       dsel;
	logic [1:0]       dword;

	assign req   = i_avs_read | i_avs_write;
	assign take  = req & ~wait_r;
	assign dsel  = i_avs_address[5:4] - 2'h2;
	assign dword = i_avs_address[3:2];
	assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
			{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

	// Register read mux; unmapped reads return zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (i_avs_address >= packer_pkg::REG_DEST_BASE &&
				i_avs_address <= packer_pkg::REG_DEST_END) begin
			unique case (dword)
				packer_pkg::DEST_BEGIN: rd_word = dest_r[dsel].addr_begin;
				packer_pkg::DEST_LAST:  rd_word = dest_r[dsel].addr_end;
				packer_pkg::DEST_PORT:  rd_word = {16'h0000, dest_r[dsel].port};
				default:                rd_word = 32'h0000_0000;
			endcase
		end else begin
			case (i_avs_address)
				packer_pkg::REG_CTRL:      rd_word = ctrl_r;
				packer_pkg::REG_FLUSH_TMO: rd_word = {16'h0000, flush_tmo_r};
				packer_pkg::REG_LISTEN:    rd_word = {16'h0000, listen_r};
				packer_pkg::REG_STREAM:    rd_word = {16'h0000, stream_r};
				packer_pkg::REG_IDLE:      rd_word = {25'h0000000, idle_r};
				packer_pkg::REG_STATUS: begin
					rd_word[packer_pkg::STAT_SENDING] = (state_r == SEND_ST);
					rd_word[packer_pkg::STAT_LINK]    = i_link_open;
					rd_word[packer_pkg::STAT_CAUSE +: 2] = cause_r;
					rd_word[packer_pkg::STAT_FILL +: CNT_W] = count_r;
				end
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	// Bus handshake and configuration writes
	always_comb begin
		wait_nxt      = ~(req & wait_r);
		rdata_nxt     = (req & wait_r) ? rd_word : rdata_r;
		ctrl_nxt      = ctrl_r;
		flush_tmo_nxt = flush_tmo_r;
		listen_nxt    = listen_r;
		stream_nxt    = stream_r;
		idle_nxt      = idle_r;
		dest_nxt      = dest_r;
		if (take && i_avs_write) begin
			if (i_avs_address >= packer_pkg::REG_DEST_BASE &&
					i_avs_address <= packer_pkg::REG_DEST_END) begin
				// [R10] Destination entries
				unique case (dword)
					packer_pkg::DEST_BEGIN: dest_nxt[dsel].addr_begin =
						(dest_r[dsel].addr_begin & ~wmask) | (i_avs_writedata & wmask);
					packer_pkg::DEST_LAST: dest_nxt[dsel].addr_end =
						(dest_r[dsel].addr_end & ~wmask) | (i_avs_writedata & wmask);
					packer_pkg::DEST_PORT: dest_nxt[dsel].port =
						(dest_r[dsel].port & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
					default: ;
				endcase
			end else begin
				case (i_avs_address)
					// [R1] Any marker values
					packer_pkg::REG_CTRL:
						ctrl_nxt = (ctrl_r & ~wmask) | (i_avs_writedata & wmask);
					// [R5] Timeout in ms
					packer_pkg::REG_FLUSH_TMO: flush_tmo_nxt =
						(flush_tmo_r & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
					// [R11] Datagram listen port
					packer_pkg::REG_LISTEN: listen_nxt =
						(listen_r & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
					// [R13] Stream listen port
					packer_pkg::REG_STREAM: stream_nxt =
						(stream_r & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
					// [R12] Minutes, capped at 99
					packer_pkg::REG_IDLE: if (i_avs_byteenable[0]) begin
						idle_nxt = (i_avs_writedata[6:0] > packer_pkg::IDLE_MAX) ?
							packer_pkg::IDLE_MAX : i_avs_writedata[6:0];
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wait_r      <= 1'b1;
			rdata_r     <= 32'h0000_0000;
			ctrl_r      <= 32'h0000_0000;
			flush_tmo_r <= packer_pkg::FLUSH_TMO_RST;
			listen_r    <= packer_pkg::PORT_RST;
			stream_r    <= packer_pkg::PORT_RST;
			idle_r      <= packer_pkg::IDLE_RST;
			for (int i = 0; i < packer_pkg::NUM_DEST; i++) begin
				dest_r[i] <= '{addr_begin: 32'h0000_0000, addr_end: 32'h0000_0000,
						port: packer_pkg::PORT_RST};
			end
		end else begin
			wait_r      <= wait_nxt;
			rdata_r     <= rdata_nxt;
			ctrl_r      <= ctrl_nxt;
			flush_tmo_r <= flush_tmo_nxt;
			listen_r    <= listen_nxt;
			stream_r    <= stream_nxt;
			idle_r      <= idle_nxt;
			dest_r      <= dest_nxt;
		end
	end

	// Millisecond tick for the frame timeout, restarted with each frame
	tick_divider #(.DIV(MS_CYCLES)) u_frame_ms (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_en    (1'b1),
		.i_clear (frame_start),
		.o_tick  (frame_ms_tick)
	);

	// Marker matching and flush conditions
	assign m1_en     = ctrl_r[packer_pkg::CTRL_M1_EN];
	assign m2_en     = ctrl_r[packer_pkg::CTRL_M2_EN];
	assign accept    = i_rx_valid & rx_ready_r;
	assign count_inc = count_r + CNT_W'(1);
	assign frame_start = accept && (count_r == '0);
	assign hit1 = m1_en && (i_rx_data == ctrl_r[packer_pkg::CTRL_M1_LSB +: 8]);
	assign hit2 = m2_en && match_r && (i_rx_data == ctrl_r[packer_pkg::CTRL_M2_LSB +: 8]);
	// [R4] Markers act only with marker1 on
	assign marker_flush = accept && m1_en && (m2_en ? hit2 : hit1);
	// [R3] Buffer full
	assign full_flush   = accept && (count_inc == FULL);
	// [R5] Zero disables timeout
	assign tmo_flush    = (state_r == FILL_ST) && (count_r != '0) &&
			(flush_tmo_r != 16'h0000) && (ms_cnt_r >= flush_tmo_r);

	// Buffer write port
	always_ff @(posedge i_clk) begin
		// [R7] Store serial bytes
		if (accept) begin
			mem[count_r[AW-1:0]] <= i_rx_data;
		end
	end

	// Frame fill and send
	always_comb begin
		state_nxt    = state_r;
		count_nxt    = count_r;
		len_nxt      = len_r;
		rd_nxt       = rd_r;
		match_nxt    = match_r;
		ms_cnt_nxt   = ms_cnt_r;
		rx_ready_nxt = rx_ready_r;
		tx_valid_nxt = tx_valid_r;
		tx_nxt       = tx_r;
		cause_nxt    = cause_r;
		unique case (state_r)
			FILL_ST: begin
				// [R6] Interval counted from first byte
				if (frame_start) begin
					ms_cnt_nxt = 16'h0000;
				end else if (frame_ms_tick && count_r != '0 && ms_cnt_r != 16'hFFFF) begin
					ms_cnt_nxt = ms_cnt_r + 16'h0001;
				end
				if (accept) begin
					count_nxt = count_inc;
					// [R1] Marker1 arms marker2
					match_nxt = m2_en && hit1 && !hit2;
				end
				if (marker_flush || full_flush || tmo_flush) begin
					// [R14] Start empty next frame
					state_nxt    = SEND_ST;
					len_nxt      = accept ? count_inc : count_r;
					count_nxt    = '0;
					match_nxt    = 1'b0;
					ms_cnt_nxt   = 16'h0000;
					rd_nxt       = '0;
					rx_ready_nxt = 1'b0;
					// [R2] Marker flush cause
					cause_nxt    = marker_flush ? packer_pkg::CAUSE_MARKER :
							full_flush ? packer_pkg::CAUSE_FULL : packer_pkg::CAUSE_TIMEOUT;
				end
			end
			SEND_ST: begin
				if (tx_valid_r && i_tx_ready && tx_r.last) begin
					state_nxt    = FILL_ST;
					tx_valid_nxt = 1'b0;
					rx_ready_nxt = 1'b1;
				end else if (!tx_valid_r || i_tx_ready) begin
					tx_valid_nxt = (rd_r != len_r);
					if (rd_r != len_r) begin
						tx_nxt.data = mem[rd_r[AW-1:0]];
						tx_nxt.last = (rd_r == len_r - CNT_W'(1));
						rd_nxt      = rd_r + CNT_W'(1);
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r    <= FILL_ST;
			count_r    <= '0;
			len_r      <= '0;
			rd_r       <= '0;
			match_r    <= 1'b0;
			ms_cnt_r   <= 16'h0000;
			rx_ready_r <= 1'b1;
			tx_valid_r <= 1'b0;
			tx_r       <= '0;
			cause_r    <= 2'h0;
		end else begin
			state_r    <= state_nxt;
			count_r    <= count_nxt;
			len_r      <= len_nxt;
			rd_r       <= rd_nxt;
			match_r    <= match_nxt;
			ms_cnt_r   <= ms_cnt_nxt;
			rx_ready_r <= rx_ready_nxt;
			tx_valid_r <= tx_valid_nxt;
			tx_r       <= tx_nxt;
			cause_r    <= cause_nxt;
		end
	end

	// Minute ticks for link idleness, restarted by activity
	assign link_clear = i_link_activity | ~i_link_open | close_r;

	tick_divider #(.DIV(MS_CYCLES)) u_link_ms (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_en    (1'b1),
		.i_clear (link_clear),
		.o_tick  (link_ms_tick)
	);

	tick_divider #(.DIV(MS_PER_MIN)) u_link_min (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_en    (link_ms_tick),
		.i_clear (link_clear),
		.o_tick  (link_min_tick)
	);

	// Idle link supervision
	always_comb begin
		idle_min_nxt = idle_min_r;
		close_nxt    = 1'b0;
		if (link_clear) begin
			idle_min_nxt = 7'h00;
		end else if (idle_r != 7'h00 && idle_min_r >= idle_r) begin
			// [R12] Close after idle minutes
			close_nxt    = 1'b1;
			idle_min_nxt = 7'h00;
		end else if (link_min_tick && idle_min_r != 7'h7F) begin
			idle_min_nxt = idle_min_r + 7'h01;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			idle_min_r <= 7'h00;
			close_r    <= 1'b0;
		end else begin
			idle_min_r <= idle_min_nxt;
			close_r    <= close_nxt;
		end
	end

	// Outputs straight from flops
	assign o_avs_readdata       = rdata_r;
	assign o_avs_waitrequest    = wait_r;
	assign o_rx_ready           = rx_ready_r;
	assign o_tx                 = tx_r;
	assign o_tx_valid           = tx_valid_r;
	assign o_dest               = dest_r;
	assign o_listen_port        = listen_r;
	assign o_stream_listen_port = stream_r;
	assign o_link_close         = close_r;
endmodule // serial_to_datagram_packer
`default_nettype wire

// file: src/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
	parameter int unsigned DIV = 50000
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// Count control
	input  wire logic i_en,
	input  wire logic i_clear,
	// One-cycle tick
	output logic      o_tick
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] TOP = W'(DIV - 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_nxt;

	// Count enables, wrap with a tick
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (i_clear) begin
			cnt_nxt = '0;
		end else if (i_en) begin
			if (cnt_r == TOP) begin
				cnt_nxt  = '0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			o_tick <= tick_nxt;
		end
	end
endmodule // tick_divider
`default_nettype wire
